/* eis_pkg.sv */
// constants and types of the external pin interrupt sense block
package eis_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WDT_PERIOD_NS = 1000;
  localparam int unsigned WDT_SAMPLE_CYC = (WDT_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CYC_DEF = 1024;

  // ----------------------------------------------------------------
  // pin groups and bus widths
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned LOW_PINS = 4;
  localparam int unsigned SENSE_W = 2;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SENSE_LOW = 8'h6a;
  localparam logic [7:0] IDX_SENSE_HIGH = 8'h70;
  localparam logic [7:0] IDX_MASK = 8'h59;
  localparam logic [7:0] IDX_FLAG = 8'h58;
  localparam logic [7:0] IDX_WAKE = 8'h71;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SENSE_LOW = 8'h00;
  localparam logic [7:0] RST_SENSE_HIGH = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic RST_PIN_LEVEL = 1'b1;

  // ----------------------------------------------------------------
  // wake status register bit positions
  // ----------------------------------------------------------------
  localparam int unsigned WAKE_BIT_STARTUP = 0;
  localparam int unsigned WAKE_BIT_ARMED = 1;
  localparam int unsigned WAKE_BIT_BY_LEVEL = 2;
  localparam int unsigned WAKE_BIT_BY_EDGE = 3;

  // ----------------------------------------------------------------
  // sense codes and wake states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } eis_sense_t;

  typedef enum logic [2:0] {
    WK_AWAKE = 3'h1,
    WK_ARMED = 3'h2,
    WK_STARTUP = 3'h4
  } eis_wake_t;

endpackage : eis_pkg

/* eis_sync.sv */
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module eis_sync #(
  parameter int unsigned W = 8,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ----------------------------------------------------------------
  // per bit chain; first stage feeds only the second
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_q;
      logic stab_q;
      // two stage chain
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q <= RST_VAL;
          stab_q <= RST_VAL;
        end else begin
          meta_q <= din[gi];
          stab_q <= meta_q;
        end
      end
      assign dout[gi] = stab_q;
    end
  endgenerate

endmodule : eis_sync

/* eis_sense.sv */
// external pin interrupt sense, flag, mask and wake logic
// How it works
// RL1: pins raise interrupts from pad level, even while driven as outputs by the port.
// RL2: level mode keeps the request high for as long as the pin is low.
// RL3: upper four pins detect edges only while the I/O clock runs.
// RL4: low level on all pins and lower-pin edges work with I/O clock stopped.
// RL5: in deep sleep a level wake samples the pin twice on watchdog ticks.
// RL6: two low samples wake the part; holding through start-up then interrupts.
// RL7: level gone before start-up ends: part wakes but raises no interrupt.
// RL8: lower sense register resets to zero; hidden in compatibility mode.
// RL9: a request needs global enable and the pin's mask bit.
// RL10: the driver must hold a low level until the running instruction ends.
// RL11: lower codes: 00 low level, 01 reserved, 10 falling, 11 rising.
// RL12: changing a sense code while enabled may raise a spurious request.
// RL13: software masks, changes the code, clears the flag, then unmasks.
// RL14: writing one to a flag bit clears it.
// RL15: upper codes: 00 low level, 01 any change, 10 falling, 11 rising.
// RL16: upper-pin pulses longer than one clock period are caught.
// RL17: flag sets on trigger, clears on service, stays clear in level mode.
// RL18: upper pins are synchronised and edges found from consecutive samples.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module eis_sense
  import eis_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = eis_pkg::STARTUP_CYC_DEF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [eis_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [eis_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [eis_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [eis_pkg::NUM_PINS-1:0] EXT_IRQ_PINS,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic IO_CLK_RUN,
  input wire logic SLEEP_DEEP,
  input wire logic COMPAT_MODE,
  input wire logic [eis_pkg::NUM_PINS-1:0] IRQ_SERVICED,
  output logic [eis_pkg::NUM_PINS-1:0] IRQ_REQ,
  output logic IRQ,
  output logic WAKE
);
  import eis_pkg::*;

  localparam int unsigned CNT_W = $clog2(STARTUP_CYCLES + 1);
  localparam int unsigned WDT_W = $clog2(WDT_SAMPLE_CYC + 1);

  // ----------------------------------------------------------------
  // registers and nets
  // ----------------------------------------------------------------
  logic [REG_W-1:0] sense_ctrl_low_group_q;
  logic [REG_W-1:0] sense_ctrl_high_group_q;
  logic [REG_W-1:0] ext_irq_mask_reg_q;
  logic [NUM_PINS-1:0] ext_irq_pending_flag_q;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev_q;
  logic [NUM_PINS-1:0] pin_evt;
  logic [NUM_PINS-1:0] level_mode;
  logic [NUM_PINS-1:0] level_req;
  logic [NUM_PINS-1:0] flag_clr;
  logic [NUM_PINS-1:0] req_d;
  logic [NUM_PINS-1:0] wake_samp_q;
  logic [NUM_PINS-1:0] wake_lvl_hit;
  logic [2*NUM_PINS-1:0] sense_all;
  logic waitreq_q;
  logic [DATA_W-1:0] rdata_q;
  logic bus_req;
  logic wr_fire;
  logic rd_take;
  logic [7:0] reg_idx;
  logic [REG_W-1:0] wdata8;
  logic wake_q;
  logic irq_q;
  logic [NUM_PINS-1:0] irq_req_q;
  eis_wake_t wk_state_q;
  logic [CNT_W-1:0] start_cnt_q;
  logic [WDT_W-1:0] wdt_cnt_q;
  logic wdt_tick;
  logic wake_edge_hit;
  logic wake_by_level_q;
  logic wake_by_edge_q;
  logic lvl_allowed;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // pad level is sampled, so a pin driven as an output still triggers (see RL1)
  eis_sync #(
    .W(NUM_PINS),
    .RST_VAL(RST_PIN_LEVEL)
  ) u_pin_sync (
    .clk(MCLK),
    .rst(RST),
    .din(EXT_IRQ_PINS),
    .dout(pin_sync)
  );

  // previous synchronised sample for edge compare
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_prev_q <= {NUM_PINS{RST_PIN_LEVEL}};
    end else begin
      pin_prev_q <= pin_sync; // see RL18
    end
  end

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  assign bus_req = AVS_READ | AVS_WRITE;
  assign reg_idx = AVS_ADDRESS[ADDR_W-1:2];
  assign wdata8 = AVS_WRITEDATA[REG_W-1:0];
  // a write is taken on the edge where waitrequest is seen low
  assign wr_fire = AVS_WRITE & ~waitreq_q & AVS_BYTEENABLE[0];
  assign rd_take = AVS_READ & waitreq_q;

  // one wait cycle, then release for exactly one edge
  always_ff @(posedge MCLK) begin
    if (RST) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= ~(bus_req & waitreq_q);
    end
  end

  // read data registered during the wait cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_q <= '0;
    end else if (rd_take) begin
      rdata_q <= '0;
      unique case (reg_idx)
        IDX_SENSE_LOW: rdata_q[REG_W-1:0] <= COMPAT_MODE ? '0 : sense_ctrl_low_group_q; // see RL8
        IDX_SENSE_HIGH: rdata_q[REG_W-1:0] <= sense_ctrl_high_group_q;
        IDX_MASK: rdata_q[REG_W-1:0] <= ext_irq_mask_reg_q;
        IDX_FLAG: rdata_q[REG_W-1:0] <= ext_irq_pending_flag_q;
        IDX_WAKE: begin
          rdata_q[WAKE_BIT_STARTUP] <= (wk_state_q == WK_STARTUP);
          rdata_q[WAKE_BIT_ARMED] <= (wk_state_q == WK_ARMED);
          rdata_q[WAKE_BIT_BY_LEVEL] <= wake_by_level_q;
          rdata_q[WAKE_BIT_BY_EDGE] <= wake_by_edge_q;
        end
        default: rdata_q <= '0; // unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // lower group sense codes; unreachable in compatibility mode
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sense_ctrl_low_group_q <= RST_SENSE_LOW; // see RL8
    end else if (wr_fire && reg_idx == IDX_SENSE_LOW && !COMPAT_MODE) begin
      sense_ctrl_low_group_q <= wdata8; // see RL8
    end
  end

  // upper group sense codes
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sense_ctrl_high_group_q <= RST_SENSE_HIGH;
    end else if (wr_fire && reg_idx == IDX_SENSE_HIGH) begin
      sense_ctrl_high_group_q <= wdata8;
    end
  end

  // per pin enable mask
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ext_irq_mask_reg_q <= RST_MASK;
    end else if (wr_fire && reg_idx == IDX_MASK) begin
      ext_irq_mask_reg_q <= wdata8;
    end
  end

  // ----------------------------------------------------------------
  // per pin sense decode
  // ----------------------------------------------------------------
  assign sense_all = {sense_ctrl_high_group_q, sense_ctrl_low_group_q};
  // code changes take effect at once, no glitch filter (see RL12)
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      eis_sense_t code;
      logic rise;
      logic fall;
      logic clk_ok;
      assign code = eis_sense_t'(sense_all[SENSE_W*gp +: SENSE_W]);
      assign rise = pin_sync[gp] & ~pin_prev_q[gp]; // see RL16
      assign fall = ~pin_sync[gp] & pin_prev_q[gp]; // see RL16
      // lower edges need no I/O clock; upper ones do
      if (gp < LOW_PINS) begin : g_low
        assign clk_ok = 1'b1; // see RL4
      end else begin : g_high
        assign clk_ok = IO_CLK_RUN; // see RL3
      end
      assign level_mode[gp] = (code == SENSE_LOW);
      // decode of the two bit code per group
      always_comb begin
        pin_evt[gp] = 1'b0;
        unique case (code)
          SENSE_LOW: pin_evt[gp] = 1'b0;
          SENSE_ANY: pin_evt[gp] = (gp >= LOW_PINS) && clk_ok && (rise | fall); // see RL11 RL15
          SENSE_FALL: pin_evt[gp] = clk_ok & fall; // see RL11 RL15
          SENSE_RISE: pin_evt[gp] = clk_ok & rise; // see RL11 RL15
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign flag_clr = IRQ_SERVICED | ((wr_fire && reg_idx == IDX_FLAG) ? wdata8 : '0); // see RL14

  // set wins over clear; level mode holds them clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ext_irq_pending_flag_q <= RST_FLAG;
    end else begin
      ext_irq_pending_flag_q <= ((ext_irq_pending_flag_q & ~flag_clr) | pin_evt) & ~level_mode; // see RL17
    end
  end

  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  // level requests wait until the core is awake and start-up is over
  assign lvl_allowed = (wk_state_q == WK_AWAKE) && !SLEEP_DEEP; // see RL7
  assign level_req = level_mode & ~pin_sync & {NUM_PINS{lvl_allowed}}; // see RL2
  assign req_d = (ext_irq_pending_flag_q | level_req) & ext_irq_mask_reg_q & {NUM_PINS{GLOBAL_IRQ_EN}}; // see RL9

  // registered requests to the core and the summary line
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_req_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_req_q <= req_d; // see RL2
      irq_q <= |req_d;
    end
  end

  // ----------------------------------------------------------------
  // watchdog oscillator sample tick
  // ----------------------------------------------------------------
  assign wdt_tick = (wdt_cnt_q == WDT_W'(WDT_SAMPLE_CYC - 1));

  // free count of one watchdog period while sleep is armed
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wdt_cnt_q <= '0;
    end else if (wk_state_q != WK_ARMED || wdt_tick) begin
      wdt_cnt_q <= '0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // level wake sampling
  // ----------------------------------------------------------------
  // second consecutive low sample of an enabled level pin wakes the part
  assign wake_lvl_hit = {NUM_PINS{wdt_tick}} & wake_samp_q & ~pin_sync & level_mode & ext_irq_mask_reg_q; // see RL5
  // edges on lower pins are seen without the I/O clock
  assign wake_edge_hit = |(ext_irq_pending_flag_q[LOW_PINS-1:0] & ext_irq_mask_reg_q[LOW_PINS-1:0]); // see RL4

  // remembers which pins were low at the previous tick
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wake_samp_q <= '0;
    end else if (wk_state_q != WK_ARMED) begin
      wake_samp_q <= '0;
    end else if (wdt_tick) begin
      wake_samp_q <= ~pin_sync; // see RL5
    end
  end

  // ----------------------------------------------------------------
  // wake state machine
  // ----------------------------------------------------------------
  // start-up always runs out, level or not; the request path decides
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wk_state_q <= WK_AWAKE;
      start_cnt_q <= '0;
    end else begin
      unique case (wk_state_q)
        WK_AWAKE: begin
          if (SLEEP_DEEP) begin
            wk_state_q <= WK_ARMED;
          end
        end
        WK_ARMED: begin
          if (|wake_lvl_hit || wake_edge_hit) begin
            wk_state_q <= WK_STARTUP; // see RL6
            start_cnt_q <= CNT_W'(STARTUP_CYCLES);
          end else if (!SLEEP_DEEP) begin
            wk_state_q <= WK_AWAKE;
          end
        end
        WK_STARTUP: begin
          if (start_cnt_q == '0) begin
            wk_state_q <= WK_AWAKE; // see RL6 RL7
          end else begin
            start_cnt_q <= start_cnt_q - CNT_W'(1);
          end
        end
        default: begin
          wk_state_q <= WK_AWAKE;
          start_cnt_q <= '0;
        end
      endcase
    end
  end

  // wake pulse and cause of the last wake
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wake_q <= 1'b0;
      wake_by_level_q <= 1'b0;
      wake_by_edge_q <= 1'b0;
    end else begin
      wake_q <= (wk_state_q == WK_ARMED) && (|wake_lvl_hit || wake_edge_hit); // see RL6
      if (wk_state_q == WK_ARMED && (|wake_lvl_hit || wake_edge_hit)) begin
        wake_by_level_q <= |wake_lvl_hit;
        wake_by_edge_q <= wake_edge_hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = waitreq_q;
  assign IRQ_REQ = irq_req_q;
  assign IRQ = irq_q;
  assign WAKE = wake_q;

endmodule : eis_sense

/* eis_sense_sva.sv */
// assertion checker for the external pin interrupt sense block
`timescale 1ns/1ps
module eis_sense_sva
  import eis_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = eis_pkg::STARTUP_CYC_DEF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [eis_pkg::DATA_W-1:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic SLEEP_DEEP,
  input wire logic [eis_pkg::NUM_PINS-1:0] IRQ_REQ,
  input wire logic IRQ,
  input wire logic WAKE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----
  // bus handshake: one wait cycle, then back to waiting
  // ----
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  property p_one_wait;
    s_req |=> s_ack;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not one wait cycle");
  property p_idle_wait;
    !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low without request");
  property p_rd_hi;
    AVS_READDATA[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  property p_rd_hold;
    !AVS_READ |=> $stable(AVS_READDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  // ----
  // request gating
  // ----
  property p_irq_or;
    IRQ == (|IRQ_REQ);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq differs from request or");
  property p_gie;
    !GLOBAL_IRQ_EN |=> (IRQ_REQ == 8'h00);
  endproperty
  a_gie: assert property (p_gie) else $error("request with global enable low");
  // ----
  // wake pulse
  // ----
  property p_wake_pulse;
    WAKE |=> !WAKE [*8];
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse repeated");
  property p_wake_sleep;
    WAKE |-> $past(SLEEP_DEEP);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside deep sleep");
  c_wake: cover property (WAKE);
endmodule : eis_sense_sva

/* eis_pin_model.sv */
// model of the off-chip drivers on the interrupt pins
`timescale 1ns/1ps
module eis_pin_model (
  input wire logic clk,
  output logic [7:0] pins
);
  // idle high as through a pull-up
  initial pins = 8'hff;
  // set all pad levels after an edge
  task automatic drive(input logic [7:0] v);
    @(posedge clk);
    pins <= v;
  endtask : drive
  // low pulse of w whole cycles, held before release
  task automatic pulse(input int pin, input int w);
    drive(pins & ~(8'h01 << pin));
    repeat (w) @(posedge clk);
    pins <= 8'hff;
  endtask : pulse
endmodule : eis_pin_model

/* eis_sense_tb.sv */
// self-checking bench for the external pin interrupt sense block
`timescale 1ns/1ps
module eis_sense_tb;
  import eis_pkg::*;
  localparam int unsigned SU = 8;
  logic MCLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, GLOBAL_IRQ_EN, IO_CLK_RUN, SLEEP_DEEP, COMPAT_MODE, IRQ, WAKE;
  logic [ADDR_W-1:0] AVS_ADDRESS;
  logic [DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0] AVS_BYTEENABLE;
  logic [NUM_PINS-1:0] EXT_IRQ_PINS, IRQ_SERVICED, IRQ_REQ;
  logic [7:0] sense_q [2];
  logic [7:0] rd;
  logic [3:0] be = 4'hf;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  eis_sense #(.STARTUP_CYCLES(SU)) eis_sense_i (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_IRQ_PINS(EXT_IRQ_PINS),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IO_CLK_RUN(IO_CLK_RUN), .SLEEP_DEEP(SLEEP_DEEP), .COMPAT_MODE(COMPAT_MODE),
    .IRQ_SERVICED(IRQ_SERVICED), .IRQ_REQ(IRQ_REQ), .IRQ(IRQ), .WAKE(WAKE));
  eis_pin_model eis_pin_model_i (.clk(MCLK), .pins(EXT_IRQ_PINS));

  // 50 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  // hang guard
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // ----
  // checks and bus access
  // ----
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({7'h0, got}, {7'h0, exp});
  endtask : chk_bit
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= {24'h0, wd};
    AVS_BYTEENABLE <= be;
    // only the hang guard ends this wait
    do begin
      @(posedge MCLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA[7:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge MCLK);
  endtask : bus
  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : bus_wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk_reg(rd, exp);
  endtask : rdchk
  // mask, change code, clear flags, unmask
  task automatic set_code(input int pin, input logic [1:0] code, input logic [7:0] msk);
    bus_wr(IDX_MASK, 8'h00);
    sense_q[pin/4][2*(pin%4)+:2] = code;
    bus_wr((pin < 4) ? IDX_SENSE_LOW : IDX_SENSE_HIGH, sense_q[pin/4]);
    bus_wr(IDX_FLAG, 8'hff);
    bus_wr(IDX_MASK, msk);
  endtask : set_code
  // flag expected after one low pulse
  function automatic logic exp_flag(input int pin, input logic [1:0] code, input logic run);
    if (code == 2'h0) return 1'b0;
    if (pin < LOW_PINS) return code != 2'h1;
    return run;
  endfunction : exp_flag
  // level wake from deep sleep, pin held or dropped
  task automatic wake(input logic hold);
    int n = 0;
    set_code(0, 2'h0, 8'h01);
    SLEEP_DEEP <= 1'b1;
    eis_pin_model_i.drive(8'hfe);
    while (WAKE !== 1'b1 && n < 300) begin
      @(posedge MCLK);
      n++;
    end
    chk_bit(n > 60 && n < 300, 1'b1);
    if (!hold) eis_pin_model_i.drive(8'hff);
    repeat (SU + 6) @(posedge MCLK);
    SLEEP_DEEP <= 1'b0;
    repeat (8) @(posedge MCLK);
    chk_bit(IRQ, hold);
    rdchk(IDX_WAKE, 8'h04);
    eis_pin_model_i.drive(8'hff);
    repeat (8) @(posedge MCLK);
  endtask : wake
  // ----
  // main sequence
  // ----
  initial begin
    int pin;
    int n;
    logic [1:0] code;
    logic gie, run;
    logic [7:0] wd;
    void'($urandom(32'h4e3e));
    RST = 1'b1;
    AVS_ADDRESS = '0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = '0;
    AVS_BYTEENABLE = 4'h0;
    GLOBAL_IRQ_EN = 1'b0;
    IO_CLK_RUN = 1'b1;
    SLEEP_DEEP = 1'b0;
    COMPAT_MODE = 1'b0;
    IRQ_SERVICED = '0;
    sense_q[0] = 8'h00;
    sense_q[1] = 8'h00;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    rdchk(IDX_SENSE_LOW, RST_SENSE_LOW);
    rdchk(IDX_SENSE_HIGH, RST_SENSE_HIGH);
    rdchk(IDX_MASK, RST_MASK);
    rdchk(IDX_FLAG, RST_FLAG);
    // write without the low byte lane is ignored
    be = 4'he;
    bus_wr(IDX_MASK, 8'hff);
    be = 4'hf;
    rdchk(IDX_MASK, 8'h00);
    bus_wr(8'h10, 8'h5a);
    rdchk(8'h10, 8'h00);
    wd = 8'($urandom) | 8'h01;
    bus_wr(IDX_SENSE_LOW, wd);
    rdchk(IDX_SENSE_LOW, wd);
    // compatibility mode hides the value and refuses writes
    COMPAT_MODE <= 1'b1;
    bus_wr(IDX_SENSE_LOW, ~wd);
    rdchk(IDX_SENSE_LOW, 8'h00);
    COMPAT_MODE <= 1'b0;
    rdchk(IDX_SENSE_LOW, wd);
    bus_wr(IDX_SENSE_LOW, 8'h00);
    // each pin once, every code on each group, first, then random
    for (int i = 0; i < 32; i++) begin
      pin = (i < 8) ? i : int'($urandom_range(7, 0));
      code = (i < 8) ? 2'(i) : 2'($urandom);
      gie = (i < 8) ? 1'b1 : 1'($urandom);
      run = (i < 8) ? 1'b1 : 1'($urandom);
      GLOBAL_IRQ_EN <= gie;
      IO_CLK_RUN <= run;
      set_code(pin, code, 8'hff);
      eis_pin_model_i.pulse(pin, $urandom_range(5, 2));
      repeat (8) @(posedge MCLK);
      chk_bit(IRQ, exp_flag(pin, code, run) & gie);
      chk_reg(IRQ_REQ, 8'(exp_flag(pin, code, run) & gie) << pin);
      rdchk(IDX_FLAG, 8'(exp_flag(pin, code, run)) << pin);
    end
    // upper level request without I/O clock
    GLOBAL_IRQ_EN <= 1'b1;
    IO_CLK_RUN <= 1'b0;
    set_code(5, 2'h0, 8'h20);
    eis_pin_model_i.drive(8'hdf);
    repeat (6) @(posedge MCLK);
    repeat (4) begin
      chk_bit(IRQ, 1'b1);
      repeat (3) @(posedge MCLK);
    end
    rdchk(IDX_FLAG, 8'h00);
    eis_pin_model_i.drive(8'hff);
    repeat (8) @(posedge MCLK);
    chk_bit(IRQ, 1'b0);
    // flag set while masked, cleared by service
    IO_CLK_RUN <= 1'b1;
    set_code(2, 2'h2, 8'h00);
    eis_pin_model_i.pulse(2, 3);
    repeat (8) @(posedge MCLK);
    rdchk(IDX_FLAG, 8'h04);
    chk_bit(IRQ, 1'b0);
    IRQ_SERVICED <= 8'h04;
    @(posedge MCLK);
    IRQ_SERVICED <= 8'h00;
    rdchk(IDX_FLAG, 8'h00);
    wake(1'b0);
    wake(1'b1);
    // lower pin edge wakes with the I/O clock stopped
    IO_CLK_RUN <= 1'b0;
    set_code(1, 2'h2, 8'h02);
    SLEEP_DEEP <= 1'b1;
    eis_pin_model_i.pulse(1, 3);
    n = 0;
    while (WAKE !== 1'b1 && n < 300) begin
      @(posedge MCLK);
      n++;
    end
    chk_bit(n < 20, 1'b1);
    SLEEP_DEEP <= 1'b0;
    repeat (SU + 6) @(posedge MCLK);
    rdchk(IDX_WAKE, 8'h08);
    chk_bit(IRQ, 1'b1);
    summarize();
  end
endmodule : eis_sense_tb

bind eis_sense eis_sense_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) eis_sense_sva_i (.MCLK(MCLK), .RST(RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .SLEEP_DEEP(SLEEP_DEEP), .IRQ_REQ(IRQ_REQ), .IRQ(IRQ), .WAKE(WAKE));
